/* logic/addr_priv_pkg.sv */
// Purpose: shared constants and types of the address and privilege unit
// Assumes: one 200 MHz clock, asynchronous active-low reset
// Notes:   shared offsets, field positions and the state, mode and level reset values live here
package addr_priv_pkg;
    // request kinds from the core
    localparam logic [1:0]  KIND_CODE      = 2'h0;
    localparam logic [1:0]  KIND_DATA      = 2'h1;
    localparam logic [1:0]  KIND_STACK     = 2'h2;
    localparam logic [1:0]  KIND_PUSH      = 2'h3;
    // exception and interrupt numbers
    localparam logic [7:0]  VEC_DFAULT     = 8'h08;
    localparam logic [7:0]  VEC_STACK      = 8'h0C;
    localparam logic [7:0]  VEC_GPROT      = 8'h0D;
    localparam logic [7:0]  VEC_NMI        = 8'h02;
    // real-mode limits
    localparam logic [15:0] SEG_LAST_OFS   = 16'hFFFF;
    localparam logic [31:0] REAL_ADDR_MAX  = 32'h0010FFEF;
    localparam logic [31:0] IVT_FIRST      = 32'h00000000;
    localparam logic [31:0] IVT_LAST       = 32'h000003FF;
    localparam logic [1:0]  VEC_ENTRY_TAIL = 2'h3;
    localparam logic [3:0]  SEG_SHIFT_PAD  = 4'h0;
    localparam logic [11:0] UPPER_HIGH     = 12'hFFF;
    localparam logic [11:0] UPPER_LOW      = 12'h000;
    // shutdown exit by nmi needs this much table and stack
    localparam logic [15:0] NMI_MIN_LIMIT  = 16'h0017;
    localparam logic [15:0] NMI_MIN_SP     = 16'h0005;
    // access rights byte field holding the descriptor level
    localparam int          DLVL_MSB       = 6;
    localparam int          DLVL_LSB       = 5;
    // sync depth for pins
    localparam int          SYNC_STAGES    = 3;
    // run states
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_HALT = 2'b01,
        ST_SHUT = 2'b10
    } run_state_t;
    // reset values
    localparam run_state_t  RST_STATE      = ST_RUN;
    localparam logic        RST_PROT       = 1'b0;
    localparam logic [1:0]  RST_LEVEL      = 2'h0;
endpackage

/* logic/addr_priv_unit.sv */
// Purpose: real/protected address forming, real-mode faults, halt,
//          shutdown and privilege level arithmetic
// Assumes: core presents one request per cycle; descriptor base,
//          access byte and paging result come from outside
// Notes:   nmi and maskable request are pins, synchronised here
// Behaviour
// - start in real mode after reset
// - real mode drives only low address lines
// - upper lines high on code until far transfer
// - real address is segment times sixteen plus offset
// - no paging in real mode
// - offset past FFFFH raises exception 13
// - stack overrun raises 12, return at fault
// - vector beyond table limit raises exception 8
// - never raise 10, 11 or 14 in real mode
// - vectors sit at number times four, low 1K
// - halt leaves bus, exits on nmi, enabled interrupt
// - halt exit saves address after halt
// - exception 8 or 13 beyond limit shuts down
// - odd stack pointer wrap shuts down
// - nmi leaves shutdown only with room
// - protected linear is descriptor base plus offset
// - protected physical is linear unless paging
// - levels 0..3, smaller is more privileged
// - requester level from selector low bits
// - descriptor level from access byte bits 6:5
// - current level from code selector unless conforming
// - effective level is maximum of requester, descriptor
`timescale 1ns/1ps
module addr_priv_unit
    import addr_priv_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_prot_en,    // protected mode from core
    input  wire logic        i_paging_en,  // paging enable from core
    input  wire logic        i_req_valid,  // access request
    input  wire logic [1:0]  i_req_kind,   // code, data, stack, push
    input  wire logic [1:0]  i_req_size,   // bytes minus one
    input  wire logic [15:0] i_seg_value,  // real-mode segment register
    input  wire logic [31:0] i_seg_base,   // descriptor base, protected
    input  wire logic [31:0] i_eff_addr,   // effective address
    input  wire logic [31:0] i_xlat_addr,  // paging result for request
    input  wire logic [15:0] i_stack_pointer,
    input  wire logic [15:0] i_cur_ip,     // ip of current instruction
    input  wire logic [15:0] i_next_ip,    // ip of following one
    input  wire logic        i_far_xfer,   // intersegment jump or call
    input  wire logic        i_soft_int,   // software interrupt
    input  wire logic [7:0]  i_int_vec,    // its number
    input  wire logic [15:0] i_itab_limit, // interrupt table limit
    input  wire logic        i_halt_instruction,
    input  wire logic        i_if_flag,    // interrupt enable flag
    input  wire logic        i_nmi_pin,
    input  wire logic        i_maskable_interrupt_request,
    input  wire logic [15:0] i_selector,   // selector of the access
    input  wire logic [7:0]  i_access_byte,
    input  wire logic [15:0] i_code_selector,
    input  wire logic        i_conforming,
    output logic             o_real_mode,
    output logic             o_addr_valid,
    output logic [31:0]      o_addr,       // address pins
    output logic [31:0]      o_lin_addr,
    output logic             o_exc_valid,
    output logic [7:0]       o_exc_vec,
    output logic [15:0]      o_saved_ip,
    output logic             o_vec_valid,
    output logic [31:0]      o_vec_addr,
    output logic             o_int_ack,
    output logic             o_halted,
    output logic             o_shutdown,
    output logic [1:0]       o_requester_level,
    output logic [1:0]       o_descriptor_level,
    output logic [1:0]       o_current_level,
    output logic [1:0]       o_effective_level
);
    // synchronised pins: bit 1 nmi, bit 0 maskable request
    logic [1:0]  pin_lvl;
    logic        nmi_prev_ff;     // for nmi rising edge
    logic        nxt_nmi_prev;
    run_state_t  state_ff;
    run_state_t  nxt_state;
    logic        prot_ff;         // 1 = protected mode
    logic        far_done_ff;     // intersegment transfer seen
    logic        nxt_far_done;
    logic        addr_valid_ff;
    logic        nxt_addr_valid;
    logic [31:0] addr_ff;
    logic [31:0] nxt_addr;
    logic [31:0] lin_ff;
    logic [31:0] nxt_lin;
    logic        exc_valid_ff;
    logic        nxt_exc_valid;
    logic [7:0]  exc_vec_ff;
    logic [7:0]  nxt_exc_vec;
    logic [15:0] saved_ip_ff;
    logic [15:0] nxt_saved_ip;
    logic [15:0] halt_ip_ff;      // resume point captured at halt
    logic [15:0] nxt_halt_ip;
    logic        vec_valid_ff;
    logic        nxt_vec_valid;
    logic [31:0] vec_addr_ff;
    logic [31:0] nxt_vec_addr;
    logic        int_ack_ff;
    logic        nxt_int_ack;
    logic [1:0]  rlvl_ff, dlvl_ff, clvl_ff, elvl_ff;
    logic [1:0]  nxt_rlvl, nxt_dlvl, nxt_clvl, nxt_elvl;
    // combinational helpers
    logic        is_real;
    logic        run_req;
    logic [31:0] lin_calc;
    logic [16:0] end_ofs;
    logic        overrun;
    logic        push_wrap;
    logic        int_oob;
    logic        df_oob;
    logic        gp_oob;
    logic        nmi_rise;
    logic        wake;

    pin_sync3 #(
        .W (2)
    ) u_pin_sync (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_pin     ({i_nmi_pin, i_maskable_interrupt_request}),
        .o_level   (pin_lvl)
    );

    // address and check arithmetic for the present request
    always_comb begin
        is_real  = !prot_ff;
        run_req  = i_req_valid && (state_ff == ST_RUN);
        // shift the segment left by four, then add the offset
        // in protected mode the descriptor base is used instead
        lin_calc = is_real ?
                   {UPPER_LOW, i_seg_value, SEG_SHIFT_PAD} + i_eff_addr :
                   i_seg_base + i_eff_addr;
        // last byte past FFFFH, including a straddling word
        end_ofs  = {1'b0, i_eff_addr[15:0]} + {15'h0000, i_req_size};
        overrun  = (|i_eff_addr[31:16]) || end_ofs[16];
        // a push that wraps from an odd pointer
        push_wrap = (i_req_kind == KIND_PUSH) && i_stack_pointer[0] &&
                    (i_stack_pointer <= {14'h0000, i_req_size});
        // vector entry is number times four, four bytes long
        int_oob  = {6'h00, i_int_vec, VEC_ENTRY_TAIL} > i_itab_limit;
        df_oob   = {6'h00, VEC_DFAULT, VEC_ENTRY_TAIL} > i_itab_limit;
        gp_oob   = {6'h00, VEC_GPROT, VEC_ENTRY_TAIL} > i_itab_limit;
        nmi_rise = pin_lvl[1] && !nmi_prev_ff;
        // halt wake sources; reset is the async path
        wake     = nmi_rise || (pin_lvl[0] && i_if_flag);
    end

    // main next-state logic: run, halt and shutdown
    always_comb begin
        nxt_state      = state_ff;
        nxt_nmi_prev   = pin_lvl[1];
        nxt_far_done   = far_done_ff || (is_real && i_far_xfer);
        nxt_addr_valid = 1'b0;
        nxt_addr       = addr_ff;
        nxt_lin        = lin_ff;
        nxt_exc_valid  = 1'b0;
        nxt_exc_vec    = exc_vec_ff;
        nxt_saved_ip   = saved_ip_ff;
        nxt_halt_ip    = halt_ip_ff;
        nxt_vec_valid  = 1'b0;
        nxt_vec_addr   = vec_addr_ff;
        nxt_int_ack    = 1'b0;
        case (state_ff)
            ST_RUN: begin
                if (i_halt_instruction) begin
                    // stop and keep the resume point
                    nxt_state   = ST_HALT;
                    nxt_halt_ip = i_next_ip;
                end else if (is_real && i_soft_int) begin
                    if (int_oob && df_oob) begin
                        nxt_state = ST_SHUT;
                    end else if (int_oob) begin
                        // fault points at the interrupt itself
                        nxt_exc_valid = 1'b1;
                        nxt_exc_vec   = VEC_DFAULT;
                        nxt_saved_ip  = i_cur_ip;
                        nxt_vec_valid = 1'b1;
                        nxt_vec_addr  = {22'h000000, VEC_DFAULT, 2'h0};
                    end else begin
                        nxt_vec_valid = 1'b1;
                        nxt_vec_addr  = {22'h000000, i_int_vec, 2'h0};
                        nxt_saved_ip  = i_next_ip;
                    end
                end else if (run_req && is_real && push_wrap) begin
                    nxt_state = ST_SHUT;
                end else if (run_req && is_real && overrun) begin
                    // stack overruns are 12, others 13; holds as
                    // no other number is ever raised here
                    if (!(i_req_kind == KIND_STACK ||
                          i_req_kind == KIND_PUSH) && gp_oob) begin
                        nxt_state = ST_SHUT;
                    end else begin
                        nxt_exc_valid = 1'b1;
                        nxt_saved_ip  = i_cur_ip;
                        nxt_exc_vec   = (i_req_kind == KIND_STACK ||
                                         i_req_kind == KIND_PUSH) ?
                                        VEC_STACK : VEC_GPROT;
                    end
                end else if (run_req) begin
                    nxt_addr_valid = 1'b1;
                    nxt_lin        = lin_calc;
                    if (is_real) begin
                        // no paging; upper lines low or forced high
                        nxt_addr = {(i_req_kind == KIND_CODE &&
                                     !far_done_ff) ? UPPER_HIGH :
                                    UPPER_LOW, lin_calc[19:0]};
                    end else if (i_paging_en) begin
                        nxt_addr = i_xlat_addr;
                    end else begin
                        nxt_addr = lin_calc;
                    end
                end
            end
            ST_HALT: begin
                // bus stays idle until a wake source
                if (wake) begin
                    nxt_state     = ST_RUN;
                    nxt_int_ack   = 1'b1;
                    nxt_saved_ip  = halt_ip_ff;
                    nxt_vec_valid = 1'b1;
                    nxt_vec_addr  = {22'h000000, VEC_NMI, 2'h0};
                end
            end
            ST_SHUT: begin
                // nmi needs its vector in the table and stack room
                if (nmi_rise && (i_itab_limit >= NMI_MIN_LIMIT) &&
                    (i_stack_pointer > NMI_MIN_SP)) begin
                    nxt_state     = ST_RUN;
                    nxt_int_ack   = 1'b1;
                    nxt_saved_ip  = i_cur_ip;
                    nxt_vec_valid = 1'b1;
                    nxt_vec_addr  = {22'h000000, VEC_NMI, 2'h0};
                end
            end
            default: begin
                nxt_state = ST_SHUT;
            end
        endcase
    end

    // privilege levels, all unsigned 2-bit values
    always_comb begin
        nxt_rlvl = i_selector[1:0];
        nxt_dlvl = i_access_byte[DLVL_MSB:DLVL_LSB];
        // a conforming segment keeps the caller's level
        nxt_clvl = i_conforming ? clvl_ff : i_code_selector[1:0];
        // numerically larger means less privileged
        nxt_elvl = (nxt_rlvl > nxt_dlvl) ? nxt_rlvl : nxt_dlvl;
    end

    // registers; reset lands in real mode
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff      <= RST_STATE;
            prot_ff       <= RST_PROT;
            nmi_prev_ff   <= 1'b0;
            far_done_ff   <= 1'b0;
            addr_valid_ff <= 1'b0;
            addr_ff       <= 32'h00000000;
            lin_ff        <= 32'h00000000;
            exc_valid_ff  <= 1'b0;
            exc_vec_ff    <= 8'h00;
            saved_ip_ff   <= 16'h0000;
            halt_ip_ff    <= 16'h0000;
            vec_valid_ff  <= 1'b0;
            vec_addr_ff   <= IVT_FIRST;
            int_ack_ff    <= 1'b0;
            rlvl_ff       <= RST_LEVEL;
            dlvl_ff       <= RST_LEVEL;
            clvl_ff       <= RST_LEVEL;
            elvl_ff       <= RST_LEVEL;
        end else begin
            state_ff      <= nxt_state;
            prot_ff       <= i_prot_en;
            nmi_prev_ff   <= nxt_nmi_prev;
            far_done_ff   <= nxt_far_done;
            addr_valid_ff <= nxt_addr_valid;
            addr_ff       <= nxt_addr;
            lin_ff        <= nxt_lin;
            exc_valid_ff  <= nxt_exc_valid;
            exc_vec_ff    <= nxt_exc_vec;
            saved_ip_ff   <= nxt_saved_ip;
            halt_ip_ff    <= nxt_halt_ip;
            vec_valid_ff  <= nxt_vec_valid;
            vec_addr_ff   <= nxt_vec_addr;
            int_ack_ff    <= nxt_int_ack;
            rlvl_ff       <= nxt_rlvl;
            dlvl_ff       <= nxt_dlvl;
            clvl_ff       <= nxt_clvl;
            elvl_ff       <= nxt_elvl;
        end
    end

    assign o_real_mode        = !prot_ff;
    assign o_addr_valid       = addr_valid_ff;
    assign o_addr             = addr_ff;
    assign o_lin_addr         = lin_ff;
    assign o_exc_valid        = exc_valid_ff;
    assign o_exc_vec          = exc_vec_ff;
    assign o_saved_ip         = saved_ip_ff;
    assign o_vec_valid        = vec_valid_ff;
    assign o_vec_addr         = vec_addr_ff;
    assign o_int_ack          = int_ack_ff;
    assign o_halted           = (state_ff == ST_HALT);
    assign o_shutdown         = (state_ff == ST_SHUT);
    assign o_requester_level  = rlvl_ff;
    assign o_descriptor_level = dlvl_ff;
    assign o_current_level    = clvl_ff;
    assign o_effective_level  = elvl_ff;

    // checks on what this unit drives
    chk_real_reset: assert property (@(posedge i_sys_clk)
        $rose(i_resetn) |-> !prot_ff) else $error("not real at reset");
    chk_real_sum: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) run_req && is_real && !overrun &&
        !push_wrap && !i_halt_instruction && !i_soft_int |=>
        o_addr_valid && o_lin_addr == {UPPER_LOW, $past(i_seg_value),
        SEG_SHIFT_PAD} + $past(i_eff_addr)) else $error("bad real sum");
    chk_upper_lines: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) o_addr_valid && $past(is_real) |->
        (o_addr[31:20] == UPPER_LOW) || (o_addr[31:20] == UPPER_HIGH))
        else $error("upper lines not fixed");
    chk_no_paging: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) o_addr_valid && $past(is_real) |->
        o_addr[19:0] == o_lin_addr[19:0]) else $error("real paged");
    chk_gp_fault: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) run_req && is_real && overrun &&
        i_req_kind == KIND_DATA && !i_halt_instruction && !i_soft_int
        |=> (o_exc_valid && o_exc_vec == VEC_GPROT) || o_shutdown)
        else $error("no exception 13");
    chk_ss_fault: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) run_req && is_real && overrun &&
        i_req_kind == KIND_STACK && !i_halt_instruction && !i_soft_int
        |=> o_exc_valid && o_exc_vec == VEC_STACK &&
        o_saved_ip == $past(i_cur_ip)) else $error("no exception 12");
    chk_no_bad_vec: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) o_exc_valid |-> o_exc_vec != 8'h0A &&
        o_exc_vec != 8'h0B && o_exc_vec != 8'h0E)
        else $error("forbidden exception");
    chk_halt_idle: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) o_halted ##1 o_halted |-> !o_addr_valid)
        else $error("bus used in halt");
    chk_halt_resume: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) $fell(o_halted) |-> o_int_ack &&
        o_saved_ip == halt_ip_ff) else $error("bad halt resume");
    chk_shut_stay: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) o_shutdown && i_stack_pointer <=
        NMI_MIN_SP |=> o_shutdown) else $error("left shutdown");
    chk_eff_level: assert property (@(posedge i_sys_clk)
        disable iff (!i_resetn) ##1 o_effective_level >=
        o_requester_level && o_effective_level >= o_descriptor_level &&
        (o_effective_level == o_requester_level ||
         o_effective_level == o_descriptor_level))
        else $error("bad effective level");
    cov_halt_wake: cover property (@(posedge i_sys_clk)
        disable iff (!i_resetn) $fell(o_halted));
    cov_shut_exit: cover property (@(posedge i_sys_clk)
        disable iff (!i_resetn) $fell(o_shutdown));
    cov_gp_fault: cover property (@(posedge i_sys_clk)
        disable iff (!i_resetn) o_exc_valid && o_exc_vec == VEC_GPROT);
endmodule

/* logic/pin_sync3.sv */
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to i_sys_clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
    parameter int W = 2
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_level
);
    // one chain per bit; stage one is read only by stage two
    for (genvar b = 0; b < W; b++) begin : g_bit
        logic s1_ff;      // metastability catcher
        logic s2_ff;      // first settled stage
        logic s3_ff;      // comparison stage
        logic lvl_ff;     // filtered level
        logic nxt_lvl;
        // filter: accept a level only once two settled stages agree
        always_comb begin
            nxt_lvl = lvl_ff;
            if (s2_ff == s3_ff) begin
                nxt_lvl = s3_ff;
            end
        end
        // registers only
        always_ff @(posedge i_sys_clk or negedge i_resetn) begin
            if (!i_resetn) begin
                s1_ff  <= 1'b0;
                s2_ff  <= 1'b0;
                s3_ff  <= 1'b0;
                lvl_ff <= 1'b0;
            end else begin
                s1_ff  <= i_pin[b];
                s2_ff  <= s1_ff;
                s3_ff  <= s2_ff;
                lvl_ff <= nxt_lvl;
            end
        end
        assign o_level[b] = lvl_ff;
    end
endmodule

/* sim/irq_source.sv */
// Purpose: interrupt sources that sit beside the unit
// Assumes: bench asks for pin levels; pins move off the clock
// Notes:   unequal skews keep the two pins out of phase with the clock
`timescale 1ns/1ps
module irq_source (
    input  wire logic i_nmi_req,  // wanted nmi level
    input  wire logic i_mask_req, // wanted maskable request level
    output logic      o_nmi_pin,  // nmi pin, rising edge counts
    output logic      o_mask_pin  // maskable request pin, level
);
    // pins start low so the unit never sees an unknown level
    initial begin
        o_nmi_pin = 1'b0;
        o_mask_pin = 1'b0;
    end
    // skewed copies: the sync stages must cope with any phase
    always @(i_nmi_req) o_nmi_pin <= #2.3 i_nmi_req;
    always @(i_mask_req) o_mask_pin <= #3.7 i_mask_req;
endmodule

/* sim/testbench.sv */
// Purpose: self-checking bench of the address and privilege unit
// Assumes: inputs move 1 ns after the rising edge
// Notes:   notes wait in queues until the monitor sees the pulse
`timescale 1ns/1ps
module testbench;
    import addr_priv_pkg::*;
    logic clk = 0, rstn = 0, prot = 0, pg = 0, rv = 0, far = 0, si = 0;
    logic halt_instruction = 0, ien = 0, nmi_r = 0, msk_r = 0, conf = 0, fseen = 0;
    logic nmi_p, msk_p, rm, av, ev, vv, ack, hd, sd;
    logic [1:0] kind = 0, size = 0, rl, dl, cl, el, clx = 0, mx;
    logic [15:0] seg = 0, sp = 16'h0100, cip = 16'h0200, nip = 16'h0202;
    logic [15:0] lim = 16'h03FF, sel = 0, csel = 0, sip;
    logic [31:0] base = 0, ea = 0, xl = 0, rnd = 32'hF2F2, oa, ol, va, ph;
    logic [7:0] ivec = 0, acc = 0, evec;
    logic [63:0] qa[$], qe[$], qv[$]; // expected notes per result kind
    int err_count = 0, compares = 0;
    always #2.5 clk = ~clk;
    irq_source src (.i_nmi_req(nmi_r), .i_mask_req(msk_r),
        .o_nmi_pin(nmi_p), .o_mask_pin(msk_p));
    addr_priv_unit dut (.i_sys_clk(clk), .i_resetn(rstn), .i_prot_en(prot),
        .i_paging_en(pg), .i_req_valid(rv), .i_req_kind(kind),
        .i_req_size(size), .i_seg_value(seg), .i_seg_base(base),
        .i_eff_addr(ea), .i_xlat_addr(xl), .i_stack_pointer(sp),
        .i_cur_ip(cip), .i_next_ip(nip), .i_far_xfer(far), .i_soft_int(si),
        .i_int_vec(ivec), .i_itab_limit(lim), .i_halt_instruction(halt_instruction),
        .i_if_flag(ien), .i_nmi_pin(nmi_p),
        .i_maskable_interrupt_request(msk_p), .i_selector(sel),
        .i_access_byte(acc), .i_code_selector(csel), .i_conforming(conf),
        .o_real_mode(rm), .o_addr_valid(av), .o_addr(oa), .o_lin_addr(ol),
        .o_exc_valid(ev), .o_exc_vec(evec), .o_saved_ip(sip),
        .o_vec_valid(vv), .o_vec_addr(va), .o_int_ack(ack), .o_halted(hd),
        .o_shutdown(sd), .o_requester_level(rl), .o_descriptor_level(dl),
        .o_current_level(cl), .o_effective_level(el));
    // one compare for every result; unknown bits match only unknown bits
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // a request stays up while the caller issues more back to back
    task automatic req(input logic [1:0] k, s, input logic [31:0] e);
        kind = k;
        size = s;
        ea = e;
        rv = 1;
        tick(1);
    endtask
    task automatic conclude();
        err_count += qa.size() + qe.size() + qv.size(); // unseen results
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // monitor: an unexpected pulse meets an unknown note and fails
    always @(negedge clk) begin
        if (av === 1'b1)
            cmp({ol, oa}, qa.size() ? qa.pop_front() : 'x);
        if (ev === 1'b1)
            cmp({evec, sip}, qe.size() ? qe.pop_front() : 'x);
        // acknowledge rides along: high only on halt or shutdown exit
        if (vv === 1'b1)
            cmp({ack, va, sip}, qv.size() ? qv.pop_front() : 'x);
    end
    initial begin
        #20000;
        err_count++;
        conclude();
    end
    initial begin
        tick(6);
        rstn = 1;
        cmp(rm, 1);
        // real-mode sums, top corner first; far transfer mid-way
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            seg = i ? rnd[15:0] : 16'hFFFF;
            if (i == 3) begin
                rv = 0;
                far = 1;
                fseen = 1;
                tick(1);
                far = 0;
            end
            ph = {12'h000, seg, 4'h0} + (i ? {16'h0, rnd[31:16]} : 32'hFFFF);
            // even passes are code fetches: upper lines high until far
            qa.push_back({ph, (!i[0] && !fseen) ? 12'hFFF : 12'h000,
                ph[19:0]});
            req({1'b0, i[0]}, 2'h0, {16'h0, ph[15:0] - {seg[11:0], 4'h0}});
        end
        qe.push_back({8'h0D, cip});
        req(KIND_DATA, 2'h1, 32'hFFFF);
        qe.push_back({8'h0D, cip});
        req(KIND_CODE, 2'h0, 32'h10000);
        qe.push_back({8'h0C, cip});
        req(KIND_STACK, 2'h3, 32'hFFFE);
        rv = 0;
        // software interrupts: top entry, plain, and past the limit
        si = 1;
        ivec = 8'hFF;
        qv.push_back({32'h3FC, nip});
        tick(1);
        ivec = 8'h21;
        qv.push_back({32'h84, nip});
        tick(1);
        lim = 16'h0040;
        qv.push_back({32'h20, cip});
        qe.push_back({8'h08, cip});
        tick(1);
        si = 0;
        // privilege arithmetic on random fields
        for (int i = 0; i < 16; i++) begin
            rnd = xs(rnd);
            sel = rnd[15:0];
            acc = rnd[23:16];
            csel = rnd[31:16];
            conf = rnd[5];
            if (!conf) clx = csel[1:0];
            mx = (sel[1:0] > acc[6:5]) ? sel[1:0] : acc[6:5];
            tick(1);
            cmp({rl, dl, cl, el}, {sel[1:0], acc[6:5], clx, mx});
        end
        // halt: refuses work, ignores masked request, wakes when enabled
        nip = 16'h0300;
        halt_instruction = 1;
        tick(1);
        halt_instruction = 0;
        req(KIND_DATA, 2'h0, 32'h10);
        rv = 0;
        msk_r = 1;
        tick(12);
        cmp(hd, 1);
        qv.push_back({1'b1, 32'h08, 16'h0300});
        ien = 1;
        for (int n = 0; n < 20 && hd; n++) tick(1);
        cmp(hd, 0);
        msk_r = 0;
        ien = 0;
        tick(3);
        // odd stack wrap shuts down; nmi leaves only with room
        sp = 16'h0001;
        req(KIND_PUSH, 2'h1, 32'h0);
        rv = 0;
        tick(1);
        cmp(sd, 1);
        nmi_r = 1;
        tick(12);
        cmp(sd, 1);
        nmi_r = 0;
        sp = 16'h0006;
        lim = 16'h0017;
        tick(6);
        qv.push_back({1'b1, 32'h08, cip});
        nmi_r = 1;
        for (int n = 0; n < 20 && sd; n++) tick(1);
        cmp(sd, 0);
        nmi_r = 0;
        // protected mode: base plus offset, then paging result
        prot = 1;
        tick(2);
        cmp(rm, 0);
        for (int i = 0; i < 2; i++) begin
            rnd = xs(rnd);
            base = rnd;
            pg = i[0];
            xl = ~rnd;
            qa.push_back({rnd + 32'h1234, i ? ~rnd : rnd + 32'h1234});
            req(KIND_DATA, 2'h0, 32'h1234);
        end
        rv = 0;
        tick(3);
        conclude();
    end
endmodule
